// ===== hdl/dbp_data_phase.sv
// Behaviour
// - Driver asserts occupied line while driving data
// - Take bus only after occupied deasserted
// - Data driver also drives four parity lines
// - Data-valid asserted for every data transfer
// - Valid may drop for idle clocks; ignored
// - Four data words per common clock
// - Capture on falling edges of both strobes
// - Four 16-bit groups, own strobe pair each
`timescale 1ns/1ps
module dbp_data_phase
   import dbp_pkg::*;
(
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire logic          clk_link_in,
   input  wire logic          tx_valid_in,
   input  wire logic [CW-1:0] tx_data_in,
   input  wire logic          tx_last_in,
   output wire logic          tx_ready_out,
   output wire logic          rx_valid_out,
   output wire logic [CW-1:0] rx_data_out,
   output wire logic          rx_perr_out,
   output wire logic          out_of_order_completion_n_out,
   input  wire logic [DW-1:0] bus_data_n_in,
   output wire logic [DW-1:0] bus_data_n_out,
   output wire logic          bus_data_oe_n_out,
   input  wire logic [NG-1:0] data_parity_lines_n_in,
   output wire logic [NG-1:0] data_parity_lines_n_out,
   output wire logic          data_parity_oe_n_out,
   input  wire logic [NG-1:0] pos_data_strobe_n_in,
   output wire logic [NG-1:0] pos_data_strobe_n_out,
   output wire logic          pos_data_strobe_oe_n_out,
   input  wire logic [NG-1:0] neg_data_strobe_n_in,
   output wire logic [NG-1:0] neg_data_strobe_n_out,
   output wire logic          neg_data_strobe_oe_n_out,
   input  wire logic          data_valid_n_in,
   output wire logic          data_valid_n_out,
   output wire logic          data_valid_oe_n_out,
   input  wire logic          data_bus_occupied_n_in,
   output wire logic          data_bus_occupied_n_out,
   output wire logic          data_bus_occupied_oe_n_out,
   input  wire logic          out_of_order_completion_n_in
);
   dbp_xdom_if x ();

   logic [1:0]    lrst_q;
   logic [2:0]    treq_q;
   logic          tack_q;
   logic          pend_q;
   logic          hold_last_q;
   logic [CW-1:0] hold_q;
   logic [CW-1:0] cur_q;
   logic          cur_act_q;
   logic          cur_last_q;
   logic [1:0]    ph_q;
   dbp_st_t       st_q;
   dbp_st_t       st_d;

   logic [DW-1:0] data_n_q;
   logic [NG-1:0] par_n_q;
   logic          drv_oe_n_q;
   logic          valid_n_q;
   logic [NG-1:0] stb_p_q;
   logic [NG-1:0] stb_n_q;
   logic          occ_n_q;
   logic          occ_oe_n_q;

   logic [DW-1:0] rxb_q [NW];
   logic [NG-1:0] rsp_q;
   logic [NG-1:0] rsn_q;
   logic          rx_err_q;
   logic          rx_done_q;
   logic          rx_tog_q;
   logic          rx_perr_q;
   logic [CW-1:0] rx_hold_q;

   // Link-domain reset, released on the link clock
   wire lrst_n = lrst_q[1];

   always_ff @(posedge clk_link_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'h1};
      end
   end

   // Chunk handover from the system side
   wire t_agree = treq_q[1] == treq_q[2];
   wire new_req = t_agree && (treq_q[2] != tack_q) && !pend_q;

   // Common clock phase and bus state decode
   wire ph_end   = ph_q == PH_LAST;
   wire bus_free = data_bus_occupied_n_in && data_valid_n_in;
   wire driving  = st_q == ST_DRIVE;
   wire owning   = driving || (st_q == ST_REL);
   wire fin      = cur_act_q && cur_last_q;
   wire start    = (st_q == ST_WAIT) && bus_free;
   wire cont     = driving && !fin;
   wire load     = ph_end && pend_q && (start || cont);
   wire word_on  = driving && cur_act_q;
   wire [DW-1:0] word = cur_q[{ph_q, 6'h00} +: DW];

   // Receive decode; wire word index lags the phase by one
   wire [1:0]    wix     = ph_q - 2'h1;
   wire          rx_on   = drv_oe_n_q && !data_valid_n_in;
   wire [NG-1:0] fall_p  = rsp_q & ~pos_data_strobe_n_in;
   wire [NG-1:0] fall_n  = rsn_q & ~neg_data_strobe_n_in;
   wire [NG-1:0] fall    = wix[0] ? fall_n : fall_p;
   wire [DW-1:0] rx_word = ~bus_data_n_in;
   wire [NG-1:0] rx_bad  = dbp_par_n(rx_word) ^ data_parity_lines_n_in;
   wire          rx_cap  = rx_on && (|fall);
   wire          rx_last = rx_cap && (wix == PH_LAST);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (pend_q) begin
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (ph_end && bus_free) begin
               st_d = ST_DRIVE;
            end
         end
         ST_DRIVE: begin
            if (ph_end && fin) begin
               st_d = ST_REL;
            end
         end
         ST_REL: begin
            if (ph_end) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_link_in or negedge lrst_n) begin
      if (!lrst_n) begin
         ph_q   <= PH_FIRST;
         st_q   <= ST_IDLE;
         treq_q <= 3'h0;
         tack_q <= 1'h0;
         pend_q <= 1'h0;
      end else begin
         ph_q   <= ph_q + 2'h1;
         st_q   <= st_d;
         treq_q <= {treq_q[1:0], x.tx_tog};
         if (new_req) begin
            tack_q <= treq_q[2];
            pend_q <= 1'h1;
         end else if (load) begin
            pend_q <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk_link_in) begin
      if (new_req) begin
         hold_q <= x.tx_data;
      end
      if (load) begin
         cur_q <= hold_q;
      end
   end

   // Missing chunk at a boundary becomes an idle clock
   always_ff @(posedge clk_link_in or negedge lrst_n) begin
      if (!lrst_n) begin
         hold_last_q <= 1'h0;
         cur_act_q   <= 1'h0;
         cur_last_q  <= 1'h0;
      end else begin
         if (new_req) begin
            hold_last_q <= x.tx_last;
         end
         if (load) begin
            cur_act_q  <= 1'h1;
            cur_last_q <= hold_last_q;
         end else if (ph_end) begin
            cur_act_q <= 1'h0;
         end
      end
   end

   // Pin drivers
   always_ff @(posedge clk_link_in or negedge lrst_n) begin
      if (!lrst_n) begin
         data_n_q   <= {DW{PIN_IDLE}};
         par_n_q    <= {NG{PIN_IDLE}};
         drv_oe_n_q <= OE_OFF_N;
         valid_n_q  <= PIN_IDLE;
         stb_p_q    <= {NG{PIN_IDLE}};
         stb_n_q    <= {NG{PIN_IDLE}};
         occ_n_q    <= PIN_IDLE;
         occ_oe_n_q <= OE_OFF_N;
      end else begin
         data_n_q   <= ~word;
         par_n_q    <= dbp_par_n(word);
         drv_oe_n_q <= !driving;
         valid_n_q  <= !word_on;
         stb_p_q    <= {NG{!word_on || ph_q[0]}};
         stb_n_q    <= {NG{!word_on || !ph_q[0]}};
         occ_n_q    <= !driving;
         occ_oe_n_q <= !owning;
      end
   end

   // Receive capture per group and per word
   always_ff @(posedge clk_link_in) begin
      for (int g = 0; g < NG; g++) begin
         if (rx_on && fall[g]) begin
            rxb_q[wix][g*GW +: GW] <= rx_word[g*GW +: GW];
         end
      end
      if (rx_done_q) begin
         rx_hold_q <= {rxb_q[3], rxb_q[2], rxb_q[1], rxb_q[0]};
      end
   end

   always_ff @(posedge clk_link_in or negedge lrst_n) begin
      if (!lrst_n) begin
         rsp_q     <= {NG{PIN_IDLE}};
         rsn_q     <= {NG{PIN_IDLE}};
         rx_err_q  <= 1'h0;
         rx_done_q <= 1'h0;
         rx_tog_q  <= 1'h0;
         rx_perr_q <= 1'h0;
      end else begin
         rsp_q     <= pos_data_strobe_n_in;
         rsn_q     <= neg_data_strobe_n_in;
         rx_done_q <= rx_last;
         if (rx_cap) begin
            rx_err_q <= ((wix != PH_FIRST) && rx_err_q)
                        || (|(rx_bad & fall));
         end
         if (rx_done_q) begin
            rx_perr_q <= rx_err_q;
            rx_tog_q  <= ~rx_tog_q;
         end
      end
   end

   assign x.tx_ack  = tack_q;
   assign x.rx_data = rx_hold_q;
   assign x.rx_perr = rx_perr_q;
   assign x.rx_tog  = rx_tog_q;

   dbp_sys_side u_sys (
      .clk_sys_in     (clk_sys_in),
      .rst_n_in       (rst_n_in),
      .tx_valid_in    (tx_valid_in),
      .tx_data_in     (tx_data_in),
      .tx_last_in     (tx_last_in),
      .tx_ready_out   (tx_ready_out),
      .rx_valid_out   (rx_valid_out),
      .rx_data_out    (rx_data_out),
      .rx_perr_out    (rx_perr_out),
      .out_of_order_completion_n_pin_n_in (out_of_order_completion_n_in),
      .out_of_order_completion_n_out      (out_of_order_completion_n_out),
      .x              (x.sys)
   );

   assign bus_data_n_out             = data_n_q;
   assign bus_data_oe_n_out          = drv_oe_n_q;
   assign data_parity_lines_n_out    = par_n_q;
   assign data_parity_oe_n_out       = drv_oe_n_q;
   assign pos_data_strobe_n_out      = stb_p_q;
   assign pos_data_strobe_oe_n_out   = drv_oe_n_q;
   assign neg_data_strobe_n_out      = stb_n_q;
   assign neg_data_strobe_oe_n_out   = drv_oe_n_q;
   assign data_valid_n_out           = valid_n_q;
   assign data_valid_oe_n_out        = drv_oe_n_q;
   assign data_bus_occupied_n_out    = occ_n_q;
   assign data_bus_occupied_oe_n_out = occ_oe_n_q;

   sequence s_word_run;
      !valid_n_q [*4];
   endsequence

   sequence s_release;
      (occ_n_q && !occ_oe_n_q) [*4] ##1 occ_oe_n_q;
   endsequence

   a_busy_covers_drive: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      !drv_oe_n_q |-> (!occ_n_q && !occ_oe_n_q))
      else $error("data driven without occupied line");

   a_wait_bus_free: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      (st_q == ST_WAIT && !bus_free) |=> !driving)
      else $error("bus taken while still occupied");

   a_release_held: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      $rose(occ_n_q) |-> s_release)
      else $error("occupied line released too early");

   a_parity_tracks: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      !drv_oe_n_q |-> (par_n_q == dbp_par_n(~data_n_q)))
      else $error("parity lines do not match data");

   a_quad_words: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      ($fell(valid_n_q) && !drv_oe_n_q) |-> s_word_run)
      else $error("chunk shorter than four words");

   a_strobe_order: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      !valid_n_q |-> (stb_p_q == {NG{wix[0]}}
                      && stb_n_q == {NG{!wix[0]}}))
      else $error("strobe pattern wrong for word");

   a_idle_quiet: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      (valid_n_q && !drv_oe_n_q) |-> (&stb_p_q && &stb_n_q))
      else $error("strobes toggled in idle clock");

   a_rx_forward: assert property (@(posedge clk_link_in)
      disable iff (!lrst_n)
      rx_last |-> ##2 (rx_tog_q != $past(rx_tog_q, 2)))
      else $error("received chunk not forwarded");
endmodule : dbp_data_phase

// ===== hdl/dbp_pkg.sv
package dbp_pkg;
   localparam int         DW       = 64;
   localparam int         GW       = 16;
   localparam int         NG       = 4;
   localparam int         NW       = 4;
   localparam int         CW       = DW * NW;
   localparam logic [1:0] PH_LAST  = 2'h3;
   localparam logic [1:0] PH_FIRST = 2'h0;
   localparam logic       PIN_IDLE = 1'h1;
   localparam logic       OE_OFF_N = 1'h1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_WAIT  = 4'h2,
      ST_DRIVE = 4'h4,
      ST_REL   = 4'h8
   } dbp_st_t;

   // Pin levels of the four parity lines for one word
   function automatic logic [NG-1:0] dbp_par_n(input logic [DW-1:0] w);
      logic [NG-1:0] p;
      p = '0;
      for (int g = 0; g < NG; g++) begin
         p[g] = ~(^w[g*GW +: GW]);
      end
      return p;
   endfunction : dbp_par_n
endpackage : dbp_pkg

// ===== hdl/dbp_xdom_if.sv
`timescale 1ns/1ps
interface dbp_xdom_if;
   import dbp_pkg::*;
   logic [CW-1:0] tx_data;
   logic          tx_last;
   logic          tx_tog;
   logic          tx_ack;
   logic [CW-1:0] rx_data;
   logic          rx_perr;
   logic          rx_tog;

   modport sys  (output tx_data, tx_last, tx_tog,
                 input  tx_ack, rx_data, rx_perr, rx_tog);
   modport link (input  tx_data, tx_last, tx_tog,
                 output tx_ack, rx_data, rx_perr, rx_tog);
endinterface : dbp_xdom_if

// ===== hdl/dbp_sys_side.sv
`timescale 1ns/1ps
module dbp_sys_side
   import dbp_pkg::*;
(
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire logic          tx_valid_in,
   input  wire logic [CW-1:0] tx_data_in,
   input  wire logic          tx_last_in,
   output wire logic          tx_ready_out,
   output wire logic          rx_valid_out,
   output wire logic [CW-1:0] rx_data_out,
   output wire logic          rx_perr_out,
   input  wire logic          out_of_order_completion_n_pin_n_in,
   output wire logic          out_of_order_completion_n_out,
   dbp_xdom_if.sys            x
);
   logic [2:0]    ta_q;
   logic [2:0]    rs_q;
   logic [2:0]    df_q;
   logic          tx_ready_q;
   logic          tx_tog_q;
   logic          tx_last_q;
   logic [CW-1:0] tx_data_q;
   logic          rx_seen_q;
   logic          rx_valid_q;
   logic [CW-1:0] rx_data_q;
   logic          rx_perr_q;
   logic          out_of_order_completion_n_q;

   wire ta_agree = ta_q[1] == ta_q[2];
   wire rs_agree = rs_q[1] == rs_q[2];
   wire df_agree = df_q[1] == df_q[2];
   wire accept   = tx_valid_in && tx_ready_q;
   wire acked    = ta_agree && (ta_q[2] == tx_tog_q);
   wire rx_new   = rs_agree && (rs_q[2] != rx_seen_q);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ta_q <= 3'h0;
         rs_q <= 3'h0;
         df_q <= 3'h7;
      end else begin
         ta_q <= {ta_q[1:0], x.tx_ack};
         rs_q <= {rs_q[1:0], x.rx_tog};
         df_q <= {df_q[1:0], out_of_order_completion_n_pin_n_in};
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_ready_q <= 1'h1;
         tx_tog_q   <= 1'h0;
         tx_last_q  <= 1'h0;
      end else if (accept) begin
         tx_ready_q <= 1'h0;
         tx_tog_q   <= ~tx_tog_q;
         tx_last_q  <= tx_last_in;
      end else if (acked) begin
         tx_ready_q <= 1'h1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (accept) begin
         tx_data_q <= tx_data_in;
      end
      if (rx_new) begin
         rx_data_q <= x.rx_data;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_seen_q  <= 1'h0;
         rx_valid_q <= 1'h0;
         rx_perr_q  <= 1'h0;
         out_of_order_completion_n_q    <= 1'h0;
      end else begin
         rx_valid_q <= rx_new;
         if (rx_new) begin
            rx_seen_q <= rs_q[2];
            rx_perr_q <= x.rx_perr;
         end
         if (df_agree) begin
            out_of_order_completion_n_q <= ~df_q[2];
         end
      end
   end

   assign x.tx_data    = tx_data_q;
   assign x.tx_last    = tx_last_q;
   assign x.tx_tog     = tx_tog_q;
   assign tx_ready_out = tx_ready_q;
   assign rx_valid_out = rx_valid_q;
   assign rx_data_out  = rx_data_q;
   assign rx_perr_out  = rx_perr_q;
   assign out_of_order_completion_n_out    = out_of_order_completion_n_q;

   a_out_of_order_completion_n_level: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      (df_agree && !df_q[2]) |=> out_of_order_completion_n_q)
      else $error("out_of_order_completion_n level not forwarded");

   a_tx_accept_tog: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      accept |=> (!tx_ready_q && (tx_tog_q != $past(tx_tog_q))))
      else $error("accepted chunk not handed over");
endmodule : dbp_sys_side

// ===== dv/dbp_agent.sv
`timescale 1ns/1ps
module dbp_agent
   import dbp_pkg::*;
(
   input  wire logic          clk_link_in,
   input  wire logic          rst_n_in,
   input  wire logic [DW-1:0] data_w_in,
   input  wire logic [NG-1:0] par_w_in,
   input  wire logic [NG-1:0] pos_w_in,
   input  wire logic [NG-1:0] neg_w_in,
   input  wire logic          valid_w_in,
   input  wire logic          occ_w_in,
   input  wire logic          dut_oe_n_in,
   output logic      [DW-1:0] data_n_out,
   output logic      [NG-1:0] par_n_out,
   output logic      [NG-1:0] pos_n_out,
   output logic      [NG-1:0] neg_n_out,
   output logic               valid_n_out,
   output logic               occ_n_out,
   output logic               oe_n_out,
   output logic               occ_oe_n_out
);
   typedef struct packed {
      logic [CW-1:0] d;
      logic          idle;
      logic          bad;
      logic          last;
   } dbp_ent_t;

   dbp_ent_t      q[$];
   dbp_ent_t      c;
   logic [DW-1:0] rx_q[$];
   int            err = 0;
   int            rel;
   logic [1:0]    cur_q;
   logic [1:0]    idx;
   logic [1:0]    n;
   logic          pv_q;
   logic          busy;
   logic          hold;
   logic          lastf;

   // Parity pins of one true word, one per group
   function automatic logic [NG-1:0] pins(input logic [DW-1:0] w);
      return {~^w[63:48], ~^w[47:32], ~^w[31:16], ~^w[15:0]};
   endfunction : pins

   task automatic load(input logic [CW-1:0] d, input logic i, b, l);
      q.push_back('{d, i, b, l});
   endtask : load

   always @(posedge clk_link_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {data_n_out, par_n_out, pos_n_out, neg_n_out} <= '1;
         {valid_n_out, occ_n_out, oe_n_out, occ_oe_n_out} <= '1;
         cur_q <= 2'h3;
         pv_q <= 1'b1;
         busy = 1'b0;
         hold = 1'b0;
         lastf = 1'b0;
         rel = 0;
      end else begin
         idx = (pv_q && !valid_w_in) ? 2'h0 : cur_q + 2'h1;
         n = idx + 2'h1;
         cur_q <= idx;
         pv_q <= valid_w_in;
         if (!valid_w_in && oe_n_out) begin
            rx_q.push_back(~data_w_in);
            if (occ_w_in !== 1'b0) err++;
            if (pos_w_in !== {NG{idx[0]}}) err++;
            if (neg_w_in !== {NG{~idx[0]}}) err++;
            if (par_w_in !== pins(~data_w_in)) err++;
         end
         if (!oe_n_out && !dut_oe_n_in) err++;
         if (rel != 0) begin
            rel--;
            if (rel == 0) occ_oe_n_out <= 1'b1;
         end
         if (n == 2'h0 && !busy && hold && lastf) begin
            hold = 1'b0;
            rel = 4;
            {oe_n_out, valid_n_out, occ_n_out} <= 3'h7;
            {pos_n_out, neg_n_out} <= '1;
         end else if (n == 2'h0 && !busy && q.size() != 0 &&
                      (hold || (occ_w_in && valid_w_in))) begin
            if (hold && q[0].idle) begin
               q[0].idle = 1'b0;
            end else begin
               c = q.pop_front();
               busy = 1'b1;
               hold = 1'b1;
               lastf = c.last;
            end
         end
         if (busy) begin
            data_n_out <= ~c.d[int'(n)*DW +: DW];
            par_n_out <= pins(c.d[int'(n)*DW +: DW]) ^ {1'b0, c.bad, 2'h0};
            pos_n_out <= {NG{n[0]}};
            neg_n_out <= {NG{~n[0]}};
            {valid_n_out, occ_n_out, oe_n_out, occ_oe_n_out} <= 4'h0;
            if (n == 2'h3) busy = 1'b0;
         end else if (hold) begin
            valid_n_out <= 1'b1;
            {pos_n_out, neg_n_out} <= '1;
         end
      end
   end
endmodule : dbp_agent

// ===== dv/system_bus_data_phase_signals_tb.sv
`timescale 1ns/1ps
module system_bus_data_phase_signals_tb;
   import dbp_pkg::*;
   logic          clk_sys = 1'b0;
   logic          clk_link = 1'b0;
   logic          rst_n;
   logic          tx_valid;
   logic [CW-1:0] tx_data;
   logic          tx_last;
   logic          out_of_order_completion_n_pin_n;
   wire  [CW-1:0] rx_data;
   wire           tx_ready, rx_valid, rx_perr, out_of_order_completion_n;
   wire  [DW-1:0] d_o, f_d, d_w;
   wire  [NG-1:0] p_o, sp_o, sn_o, f_p, f_sp, f_sn, p_w, sp_w, sn_w;
   wire           d_oe, p_oe, sp_oe, sn_oe, v_o, v_oe, o_o, o_oe;
   wire           f_v, f_o, f_oe, f_ooe, v_w, o_w;
   int            n_errors = 0;
   int            checks = 0;

   // Wired-AND of both parties, pulled up when released
   assign d_w  = (d_oe ? '1 : d_o) & (f_oe ? '1 : f_d);
   assign p_w  = (p_oe ? '1 : p_o) & (f_oe ? '1 : f_p);
   assign sp_w = (sp_oe ? '1 : sp_o) & (f_oe ? '1 : f_sp);
   assign sn_w = (sn_oe ? '1 : sn_o) & (f_oe ? '1 : f_sn);
   assign v_w  = (v_oe | v_o) & (f_oe | f_v);
   assign o_w  = (o_oe | o_o) & (f_ooe | f_o);

   always #12.5 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #62.5 clk_link = ~clk_link;
   end

   dbp_data_phase DUT (.clk_sys_in(clk_sys), .rst_n_in(rst_n),
      .clk_link_in(clk_link), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
      .tx_last_in(tx_last), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
      .rx_data_out(rx_data), .rx_perr_out(rx_perr), .out_of_order_completion_n_out(out_of_order_completion_n),
      .bus_data_n_in(d_w), .bus_data_n_out(d_o), .bus_data_oe_n_out(d_oe),
      .data_parity_lines_n_in(p_w), .data_parity_lines_n_out(p_o),
      .data_parity_oe_n_out(p_oe), .pos_data_strobe_n_in(sp_w),
      .pos_data_strobe_n_out(sp_o), .pos_data_strobe_oe_n_out(sp_oe),
      .neg_data_strobe_n_in(sn_w), .neg_data_strobe_n_out(sn_o),
      .neg_data_strobe_oe_n_out(sn_oe), .data_valid_n_in(v_w),
      .data_valid_n_out(v_o), .data_valid_oe_n_out(v_oe),
      .data_bus_occupied_n_in(o_w), .data_bus_occupied_n_out(o_o),
      .data_bus_occupied_oe_n_out(o_oe),
      .out_of_order_completion_n_in(out_of_order_completion_n_pin_n));

   dbp_agent FAR (.clk_link_in(clk_link), .rst_n_in(rst_n), .data_w_in(d_w),
      .par_w_in(p_w), .pos_w_in(sp_w), .neg_w_in(sn_w), .valid_w_in(v_w),
      .occ_w_in(o_w), .dut_oe_n_in(d_oe), .data_n_out(f_d), .par_n_out(f_p),
      .pos_n_out(f_sp), .neg_n_out(f_sn), .valid_n_out(f_v), .occ_n_out(f_o),
      .oe_n_out(f_oe), .occ_oe_n_out(f_ooe));

   task automatic check(input string what, input logic [CW-1:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [CW-1:0] mk(input int s);
      logic [CW-1:0] r;
      for (int k = 0; k < NW; k++) begin
         r[k*DW +: DW] = 64'h0123_4567_89AB_CDEF * (s * 4 + k + 1);
      end
      return r;
   endfunction : mk

   task automatic send(input logic [CW-1:0] d, input logic l);
      int   t;
      logic r;
      t = 0;
      @(negedge clk_sys);
      tx_valid = 1'b1;
      tx_data = d;
      tx_last = l;
      while (tx_ready !== 1'b1 && t < 400) begin
         @(negedge clk_sys);
         t++;
      end
      r = tx_ready;
      @(negedge clk_sys);
      tx_valid = 1'b0;
      check("tx_ready", CW'(r), CW'(1));
      check("tx_taken", CW'(tx_ready), CW'(0));
   endtask : send

   task automatic wait_words(input int nw, input int s0);
      int            t;
      logic [CW-1:0] e;
      t = 0;
      while (FAR.rx_q.size() < nw && t < 4000) begin
         @(negedge clk_sys);
         t++;
      end
      check("word_count", CW'(FAR.rx_q.size()), CW'(nw));
      for (int i = nw - (nw > 12 ? 4 : 12); i < nw; i++) begin
         e = mk(s0 + i / 4);
         check("word", CW'(FAR.rx_q[i]), CW'(e[(i % 4)*DW +: DW]));
      end
   endtask : wait_words

   task automatic t_tx;
      send(mk(0), 1'b0);
      send(mk(1), 1'b0);
      repeat (60) @(negedge clk_sys);
      send(mk(2), 1'b1);
      wait_words(12, 0);
      repeat (80) @(negedge clk_sys);
      check("released", CW'({d_oe, o_oe, o_w}), CW'(3'h7));
      check("agent_err", CW'(FAR.err), CW'(0));
   endtask : t_tx

   task automatic t_rx;
      int t;
      FAR.load(mk(3), 1'b0, 1'b0, 1'b0);
      FAR.load(mk(4), 1'b1, 1'b1, 1'b1);
      for (int s = 0; s < 2; s++) begin
         t = 0;
         do begin
            @(negedge clk_sys);
            t++;
         end while (rx_valid !== 1'b1 && t < 2000);
         check("rx_data", rx_data, mk(3 + s));
         check("rx_perr", CW'(rx_perr), CW'(s));
      end
   endtask : t_rx

   task automatic t_busy;
      int t;
      t = 0;
      repeat (100) @(negedge clk_sys);
      FAR.load(mk(5), 1'b0, 1'b0, 1'b1);
      while (o_w !== 1'b0 && t < 2000) begin
         @(negedge clk_sys);
         t++;
      end
      send(mk(6), 1'b1);
      check("hold_off", CW'(d_oe), CW'(1));
      wait_words(16, 3);
      check("rx_busy", rx_data, mk(5));
      check("agent_err", CW'(FAR.err), CW'(0));
   endtask : t_busy

   task automatic t_out_of_order_completion_n;
      @(negedge clk_sys);
      out_of_order_completion_n_pin_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      check("out_of_order_completion_n_on", CW'(out_of_order_completion_n), CW'(1));
      out_of_order_completion_n_pin_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("out_of_order_completion_n_off", CW'(out_of_order_completion_n), CW'(0));
   endtask : t_out_of_order_completion_n

   task automatic end_of_test;
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #300_000;
      n_errors++;
      end_of_test;
   end

   initial begin
      rst_n = 1'b0;
      tx_valid = 1'b0;
      tx_data = '0;
      tx_last = 1'b0;
      out_of_order_completion_n_pin_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (40) @(negedge clk_sys);
      t_tx;
      t_rx;
      t_busy;
      t_out_of_order_completion_n;
      end_of_test;
   end
endmodule : system_bus_data_phase_signals_tb
